// ===== core/caf_filter_top.sv
// Acceptance filter register file, paged window and match result
//
// How it works
// R1: Each of the six filters has an active bit, and only active filters can accept.
// R2: Software clears a filter's active bit before rewriting its bytes; writes to an active filter's bytes are ignored.
// R3: Pair 2/3 control holds filter 3 scale in 6:5, active in 4, filter 2 scale in 2:1, active in 0.
// R4: Pair 4/5 control uses the same layout, filter 5 above and filter 4 below.
// R5: Bits 7 and 3 of every control register read as zero whatever is written.
// R6: The low mode register holds filters 0 to 3, high-half bit odd, low-half bit even, filter 3 at 7:6.
// R7: The high mode register holds filters 5 and 4 in bits 3:0 and reads zero in 7:4.
// R8: A mode bit of 0 makes its half a mask pair, 1 makes it an identifier list.
// R9: An identifier byte bit of 0 expects dominant and 1 expects recessive.
// R10: A mask bit of 0 leaves the identifier bit out, 1 requires it to equal the expected bit.
// R11: Each filter owns eight bytes whose role follows from its scale and mode.
// R12: A mask byte uses the same bit mapping as an identifier byte.
// R13: Control and mode registers reset to zero and change only by software writes.
// R14: Filter bytes have no reset value and must be loaded before a filter is activated.
// R15: Scale and mode settings change only while the controller is in initialization mode.
// R16: A 3-bit page number selects the window, pages 2, 3 and 4 showing filter pairs 0:1, 2:3, 4:5.
// R17: An identifier is accepted when at least one active filter matches it.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
module caf_filter_top
   import caf_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   // Avalon-MM slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Controller state and incoming identifiers
   input  wire logic        i_init_mode,
   input  wire logic        i_id_valid,
   input  wire logic [31:0] i_id_word,
   // Filter result
   output logic             o_id_done,
   output logic             o_id_accept,
   output logic [2:0]       o_match_index
);
   caf_cfg_if cfg ();

   logic             rd_stb;
   logic             wr_stb;
   logic [2:0]       page_reg;
   logic [5:0]       active_reg;
   caf_scale_t       scale_reg [CAF_NUM_FILT];
   logic [11:0]      mode_reg;
   caf_byte_t        fbyte_reg [CAF_NUM_FILT][CAF_NUM_BYTES];
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   logic             done_reg;
   logic             accept_reg;
   logic [2:0]       index_reg;
   logic [5:0]       hit;
   logic             win_hit;
   logic             page_ok;
   logic [3:0]       win_word;
   logic [2:0]       win_filt;
   logic [2:0]       page_rel;
   logic             be_lo;

   caf_bus_slave u_bus (
      .i_core_clk    (i_core_clk),
      .i_rst         (i_rst),
      .i_ce          (i_ce),
      .i_read        (i_avs_read),
      .i_write       (i_avs_write),
      .o_waitrequest (o_avs_waitrequest),
      .o_rd_stb      (rd_stb),
      .o_wr_stb      (wr_stb)
   );

   caf_match u_match (
      .cfg       (cfg.user),
      .i_id_word (i_id_word),
      .o_hit     (hit)
   );

   assign cfg.active = active_reg;
   assign cfg.scale  = scale_reg;
   assign cfg.mode   = mode_reg;
   assign cfg.fbyte  = fbyte_reg;

   // Pack one control register from its two filters [R3] [R4] [R5]
   function automatic logic [7:0] ctrl_pack(input logic a_lo, input logic [1:0] s_lo,
                                            input logic a_hi, input logic [1:0] s_hi);
      logic [7:0] v;
      v = CAF_CTRL_RESET;
      v[CAF_CTRL_ACT_LO]                     = a_lo;
      v[CAF_CTRL_SCL_LO+1:CAF_CTRL_SCL_LO]   = s_lo;
      v[CAF_CTRL_ACT_HI]                     = a_hi;
      v[CAF_CTRL_SCL_HI+1:CAF_CTRL_SCL_HI]   = s_hi;
      ctrl_pack = v;
   endfunction : ctrl_pack

   // Lowest-numbered hit wins the reported index
   function automatic logic [2:0] first_hit(input logic [5:0] v);
      first_hit = 3'h0;
      for (int f = CAF_NUM_FILT - 1; f >= 0; f--) begin
         if (v[f]) begin
            first_hit = 3'(f);
         end
      end
   endfunction : first_hit

   // Window decode: pages 2..4 map filter pairs [R16]
   // Registers are one byte wide, so only lane 0 qualifies a write
   assign be_lo    = i_avs_byteenable[0];
   assign win_hit  = (i_avs_address >= CAF_ADDR_WIN_BASE) &&
                     (i_avs_address <= CAF_ADDR_WIN_LAST);
   assign win_word = 4'((i_avs_address - CAF_ADDR_WIN_BASE) >> 2);
   assign page_ok  = (page_reg >= CAF_PAGE_F01) && (page_reg <= CAF_PAGE_F45);
   assign page_rel = page_reg - CAF_PAGE_F01;
   assign win_filt = {page_rel[1:0], win_word[3]};

   // Any page is kept; pages outside 2..4 leave the window reading zero
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         page_reg <= CAF_PAGE_RESET;
      end else if (i_ce && wr_stb && be_lo && i_avs_address == CAF_ADDR_PAGE) begin
         page_reg <= i_avs_writedata[2:0]; // [R16]
      end
   end

   // Active bits follow software at any time [R1] [R13]
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         active_reg <= 6'h00;
      end else if (i_ce && wr_stb && be_lo) begin
         for (int p = 0; p < 3; p++) begin
            if (i_avs_address == CAF_ADDR_CTRL01 + 8'(4 * p)) begin
               active_reg[2*p]   <= i_avs_writedata[CAF_CTRL_ACT_LO];
               active_reg[2*p+1] <= i_avs_writedata[CAF_CTRL_ACT_HI];
            end
         end
      end
   end

   // Scale fields move only in initialization mode [R15] [R13]
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int f = 0; f < CAF_NUM_FILT; f++) begin
            scale_reg[f] <= CAF_SCALE_8;
         end
      end else if (i_ce && wr_stb && be_lo && i_init_mode) begin
         for (int p = 0; p < 3; p++) begin
            if (i_avs_address == CAF_ADDR_CTRL01 + 8'(4 * p)) begin
               scale_reg[2*p]   <= i_avs_writedata[CAF_CTRL_SCL_LO+1:CAF_CTRL_SCL_LO];
               scale_reg[2*p+1] <= i_avs_writedata[CAF_CTRL_SCL_HI+1:CAF_CTRL_SCL_HI];
            end
         end
      end
   end

   // Mode bits: filter f low half at 2f, high half at 2f+1 [R6] [R7] [R15]
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg <= CAF_MODE_RESET; // [R13]
      end else if (i_ce && wr_stb && be_lo && i_init_mode) begin
         if (i_avs_address == CAF_ADDR_MODE_LO) begin
            mode_reg[7:0] <= i_avs_writedata[7:0];
         end else if (i_avs_address == CAF_ADDR_MODE_HI) begin
            mode_reg[11:8] <= i_avs_writedata[3:0];
         end
      end
   end

   // Filter bytes carry no reset: software loads them first [R14] [R11]
   // Blocking writes to a live filter avoids comparing a half-updated pair
   always_ff @(posedge i_core_clk) begin
      if (i_ce && wr_stb && be_lo && win_hit && page_ok && !active_reg[win_filt]) begin
         fbyte_reg[win_filt][win_word[2:0]] <= i_avs_writedata[7:0]; // [R2]
      end
   end

   // Read mux; unmapped words and foreign pages read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (win_hit) begin
         if (page_ok) begin
            rdata_next[7:0] = fbyte_reg[win_filt][win_word[2:0]]; // [R16]
         end
      end else begin
         case (i_avs_address)
            CAF_ADDR_PAGE:    rdata_next[2:0] = page_reg;
            CAF_ADDR_CTRL01:  rdata_next[7:0] = ctrl_pack(active_reg[0], scale_reg[0],
                                                          active_reg[1], scale_reg[1]);
            CAF_ADDR_CTRL23:  rdata_next[7:0] = ctrl_pack(active_reg[2], scale_reg[2],
                                                          active_reg[3], scale_reg[3]);
            CAF_ADDR_CTRL45:  rdata_next[7:0] = ctrl_pack(active_reg[4], scale_reg[4],
                                                          active_reg[5], scale_reg[5]);
            CAF_ADDR_MODE_LO: rdata_next[7:0] = mode_reg[7:0];
            CAF_ADDR_MODE_HI: rdata_next[3:0] = mode_reg[11:8]; // [R7]
            CAF_ADDR_STATUS:  rdata_next[CAF_STAT_ACC:0] = {accept_reg, index_reg};
            default:          rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Held between reads, so a late sample by the master still sees it
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (i_ce && rd_stb) begin
         rdata_reg <= rdata_next;
      end
   end

   // Result of one identifier, registered one cycle after it is offered
   // Accept and index hold until the next offer; done is a pulse
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         done_reg   <= 1'b0;
         accept_reg <= 1'b0;
         index_reg  <= 3'h0;
      end else if (i_ce) begin
         done_reg <= i_id_valid;
         if (i_id_valid) begin
            accept_reg <= |hit; // [R17]
            index_reg  <= first_hit(hit);
         end
      end
   end

   assign o_avs_readdata = rdata_reg;
   assign o_id_done      = done_reg;
   assign o_id_accept    = accept_reg;
   assign o_match_index  = index_reg;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   a_ctrl_reserved_zero: assert property ( // [R5]
      (rd_stb && (i_avs_address == CAF_ADDR_CTRL23 || i_avs_address == CAF_ADDR_CTRL45))
      |=> (o_avs_readdata[7] == 1'b0 && o_avs_readdata[3] == 1'b0))
      else $error("control reserved bit read as one");

   a_mode_hi_zero: assert property ( // [R7]
      (rd_stb && i_avs_address == CAF_ADDR_MODE_HI) |=> (o_avs_readdata[7:4] == 4'h0))
      else $error("high mode register upper bits not zero");

   a_inactive_no_accept: assert property ( // [R1]
      (i_ce && i_id_valid && active_reg == 6'h00) |=> (o_id_done && !o_id_accept))
      else $error("identifier accepted with no active filter");

   a_ctrl_sw_only: assert property ( // [R13]
      !(wr_stb && i_avs_address == CAF_ADDR_CTRL23) |=> $stable(active_reg[3:2]))
      else $error("control bits changed without a write");

   a_window_page: assert property ( // [R16]
      (rd_stb && page_reg == CAF_PAGE_F23 && i_avs_address == CAF_ADDR_WIN_BASE)
      |=> (o_avs_readdata[7:0] == $past(fbyte_reg[2][0])))
      else $error("page 3 window does not show filter 2");

   a_live_write_block: assert property ( // [R2]
      (wr_stb && page_reg == CAF_PAGE_F23 && i_avs_address == CAF_ADDR_WIN_BASE &&
       active_reg[2]) |=> $stable(fbyte_reg[2][0]))
      else $error("active filter byte was overwritten");

   a_scale_init_only: assert property ( // [R15]
      (!i_init_mode) |=> ($stable(scale_reg[2]) && $stable(mode_reg)))
      else $error("scale or mode changed outside initialization");

   a_mask_dont_care: assert property ( // [R10]
      (i_ce && i_id_valid && active_reg[0] && scale_reg[0][1] && !mode_reg[0] &&
       {fbyte_reg[0][4], fbyte_reg[0][5], fbyte_reg[0][6], fbyte_reg[0][7]} == 32'h0)
      |=> (o_id_accept && o_match_index == 3'h0))
      else $error("all-zero mask did not accept");

   a_list_exact: assert property ( // [R17]
      (i_ce && i_id_valid && active_reg[0] && scale_reg[0][1] && mode_reg[0] &&
       i_id_word == {fbyte_reg[0][0], fbyte_reg[0][1], fbyte_reg[0][2], fbyte_reg[0][3]})
      |=> (o_id_accept && o_match_index == 3'h0))
      else $error("listed identifier not accepted");

   // Bus handshake: one wait state, then one answer cycle
   a_wait_answer: assert property (
      (i_ce && o_avs_waitrequest && (i_avs_read || i_avs_write)) |=> !o_avs_waitrequest)
      else $error("request not answered");

   a_wait_one_cycle: assert property (
      (i_ce && !o_avs_waitrequest) |=> o_avs_waitrequest)
      else $error("answer longer than one cycle");

   // Identifier results
   a_done_follows_valid: assert property ( // [R17]
      i_ce |=> (o_id_done == $past(i_id_valid)))
      else $error("done not after offer");

   a_accept_any_hit: assert property ( // [R17]
      (i_ce && i_id_valid) |=> (o_id_accept == $past(|hit)))
      else $error("accept differs from hits");

   a_index_lowest: assert property ( // [R17]
      (i_ce && i_id_valid && hit[2] && hit[1:0] == 2'h0)
      |=> (o_match_index == 3'h2))
      else $error("filter 2 hit not index 2");

   a_hit_needs_active: assert property ( // [R1]
      (hit & ~active_reg) == 6'h00)
      else $error("inactive filter hit");

   // Register read-back and scale write
   a_page_readback: assert property ( // [R16]
      (rd_stb && i_avs_address == CAF_ADDR_PAGE) |=> (o_avs_readdata == 32'($past(page_reg))))
      else $error("page read wrong");

   a_mode_lo_readback: assert property ( // [R6]
      (rd_stb && i_avs_address == CAF_ADDR_MODE_LO)
      |=> (o_avs_readdata[7:0] == $past(mode_reg[7:0])))
      else $error("low mode read wrong");

   a_status_readback: assert property ( // [R17]
      (rd_stb && i_avs_address == CAF_ADDR_STATUS)
      |=> (o_avs_readdata[CAF_STAT_ACC] == $past(accept_reg)))
      else $error("status accept wrong");

   a_win_refused: assert property ( // [R16]
      (rd_stb && win_hit && !page_ok) |=> (o_avs_readdata == 32'h0000_0000))
      else $error("foreign page not zero");

   a_ctrl01_reserved: assert property ( // [R5]
      (rd_stb && i_avs_address == CAF_ADDR_CTRL01)
      |=> (o_avs_readdata[7] == 1'b0 && o_avs_readdata[3] == 1'b0))
      else $error("reserved bit read as one");

   a_scale_write: assert property ( // [R3]
      (wr_stb && be_lo && i_init_mode && i_avs_address == CAF_ADDR_CTRL23)
      |=> (scale_reg[3] == $past(i_avs_writedata[CAF_CTRL_SCL_HI+1:CAF_CTRL_SCL_HI])))
      else $error("filter 3 scale not written");

   // Main scenarios the bench should reach
   c_accept_seen:   cover property (o_id_done && o_id_accept && o_match_index != 3'h0);
   c_write_blocked: cover property (wr_stb && win_hit && page_ok && active_reg[win_filt]);
   c_list_half:     cover property (i_id_valid && (|hit) && (|mode_reg));
   c_narrow_scale:  cover property (i_id_valid && hit[0] && !scale_reg[0][1]);
   c_ce_frozen:     cover property (!i_ce && i_id_valid);
endmodule : caf_filter_top

// ===== core/caf_pkg.sv
// Constants, register map and types of the acceptance filter block
package caf_pkg;
   localparam int CAF_NUM_FILT  = 6;
   localparam int CAF_NUM_BYTES = 8;

   // Byte addresses on the register bus, one 32-bit word per register
   localparam logic [7:0] CAF_ADDR_PAGE     = 8'h00;
   localparam logic [7:0] CAF_ADDR_CTRL01   = 8'h04;
   localparam logic [7:0] CAF_ADDR_CTRL23   = 8'h08;
   localparam logic [7:0] CAF_ADDR_CTRL45   = 8'h0C;
   localparam logic [7:0] CAF_ADDR_MODE_LO  = 8'h10;
   localparam logic [7:0] CAF_ADDR_MODE_HI  = 8'h14;
   localparam logic [7:0] CAF_ADDR_STATUS   = 8'h18;
   localparam logic [7:0] CAF_ADDR_WIN_BASE = 8'h40;
   localparam logic [7:0] CAF_ADDR_WIN_LAST = 8'h7C;

   // Page numbers that map filter pairs into the window
   localparam logic [2:0] CAF_PAGE_F01 = 3'h2;
   localparam logic [2:0] CAF_PAGE_F23 = 3'h3;
   localparam logic [2:0] CAF_PAGE_F45 = 3'h4;

   // Control register field positions
   localparam int CAF_CTRL_ACT_LO = 0;
   localparam int CAF_CTRL_SCL_LO = 1;
   localparam int CAF_CTRL_ACT_HI = 4;
   localparam int CAF_CTRL_SCL_HI = 5;
   localparam int CAF_STAT_ACC    = 3;

   localparam logic [7:0]  CAF_CTRL_RESET = 8'h00;
   localparam logic [11:0] CAF_MODE_RESET = 12'h000;
   localparam logic [2:0]  CAF_PAGE_RESET = 3'h0;

   // Scale encodings: 8-bit halves, 16-bit halves, else one 32-bit filter
   localparam logic [1:0]  CAF_SCALE_8  = 2'h0;
   localparam logic [1:0]  CAF_SCALE_16 = 2'h1;
   localparam logic [15:0] CAF_WMASK_8  = 16'hFF00;
   localparam logic [15:0] CAF_WMASK_16 = 16'hFFFF;

   typedef logic [7:0] caf_byte_t;
   typedef logic [1:0] caf_scale_t;
endpackage : caf_pkg

// ===== core/caf_cfg_if.sv
// Filter configuration bundle from register file to comparators
interface caf_cfg_if
   import caf_pkg::*;
   ();
   caf_byte_t         fbyte [CAF_NUM_FILT][CAF_NUM_BYTES];
   logic [5:0]        active;
   caf_scale_t        scale [CAF_NUM_FILT];
   logic [11:0]       mode;

   modport owner (output fbyte, output active, output scale, output mode);
   modport user  (input fbyte, input active, input scale, input mode);
endinterface : caf_cfg_if

// ===== core/caf_bus_slave.sv
// Avalon-MM handshake: one accept strobe, answer one cycle later
module caf_bus_slave
   import caf_pkg::*;
(
   // Clock, reset and enable
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   // Bus request
   input  wire logic i_read,
   input  wire logic i_write,
   output logic      o_waitrequest,
   // Internal strobes
   output logic      o_rd_stb,
   output logic      o_wr_stb
);
   logic wait_reg;

   // Second cycle of a held request must not be taken again
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wait_reg <= 1'b1;
      end else if (i_ce) begin
         wait_reg <= !(wait_reg && (i_read || i_write));
      end
   end

   assign o_waitrequest = wait_reg;
   assign o_rd_stb      = i_ce && wait_reg && i_read;
   assign o_wr_stb      = i_ce && wait_reg && i_write;
endmodule : caf_bus_slave

// ===== core/caf_match.sv
// Per-filter identifier comparison against the configured bytes
module caf_match
   import caf_pkg::*;
(
   caf_cfg_if.user          cfg,
   input  wire logic [31:0] i_id_word,
   output logic [5:0]       o_hit
);
   // One half: bytes {b0,b1} expected, {b2,b3} mask or second list entry
   function automatic logic half_hit(input logic [31:0] b, input logic [15:0] in,
                                     input logic [15:0] wm, input logic list);
      logic hit_a;
      logic hit_b;
      hit_a = (((in ^ b[31:16]) & wm) == 16'h0000);
      hit_b = (((in ^ b[15:0]) & wm) == 16'h0000);
      if (list) begin
         half_hit = hit_a || hit_b;
      end else begin
         half_hit = (((in ^ b[31:16]) & b[15:0] & wm) == 16'h0000);
      end
   endfunction : half_hit

   always_comb begin
      logic [31:0] lo_b;
      logic [31:0] hi_b;
      logic [15:0] wm;
      lo_b = 32'h0000_0000;
      hi_b = 32'h0000_0000;
      wm   = CAF_WMASK_16;
      o_hit = 6'h00;
      for (int f = 0; f < CAF_NUM_FILT; f++) begin
         lo_b = {cfg.fbyte[f][0], cfg.fbyte[f][1], cfg.fbyte[f][2], cfg.fbyte[f][3]};
         hi_b = {cfg.fbyte[f][4], cfg.fbyte[f][5], cfg.fbyte[f][6], cfg.fbyte[f][7]};
         wm   = (cfg.scale[f] == CAF_SCALE_8) ? CAF_WMASK_8 : CAF_WMASK_16;
         if (cfg.scale[f] == CAF_SCALE_8 || cfg.scale[f] == CAF_SCALE_16) begin
            // Mode bit 0 writes mask, 1 writes identifier list [R8]
            o_hit[f] = half_hit(lo_b, i_id_word[31:16], wm, cfg.mode[2*f]) ||
                       half_hit(hi_b, i_id_word[31:16], wm, cfg.mode[2*f+1]);
         end else if (cfg.mode[2*f]) begin
            o_hit[f] = (i_id_word == lo_b) || (i_id_word == hi_b); // [R17]
         end else begin
            // Zero mask bits drop out, ones must equal expected level [R10] [R12]
            o_hit[f] = (((i_id_word ^ lo_b) & hi_b) == 32'h0000_0000); // [R9]
         end
         o_hit[f] = o_hit[f] && cfg.active[f]; // [R1]
      end
   end
endmodule : caf_match

// ===== bench/caf_id_src.sv
// Identifier source standing in for frames arriving from the CAN bus
module caf_id_src
(
   // Clock
   input  wire logic   i_core_clk,
   // Identifier offer
   output logic        o_id_valid,
   output logic [31:0] o_id_word
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_id_valid = 1'b0;
      o_id_word  = 32'h0000_0000;
   end

   // Word is stale once the offer ends, so show its inverse rather than hold it
   task automatic send(input logic [31:0] w);
      @(posedge i_core_clk);
      o_id_valid <= 1'b1;
      o_id_word  <= w;
      @(posedge i_core_clk);
      o_id_valid <= 1'b0;
      o_id_word  <= ~w;
   endtask : send
endmodule : caf_id_src

// ===== bench/caf_filter_top_tb.sv
// Self-checking bench for the acceptance filter block
module caf_filter_top_tb
   import caf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        init_mode;
   logic        ce;
   logic        id_valid;
   logic [31:0] id_word;
   logic        id_done;
   logic        id_accept;
   logic [2:0]  match_index;
   int          n_mismatch;
   int          samples_checked;

   localparam caf_byte_t FB [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hFF, 8'hF0, 8'h00, 8'h00};

   caf_filter_top i_caf_filter_top (
      .i_core_clk       (clk),
      .i_rst            (rst),
      .i_ce             (ce),
      .i_avs_address    (avs_address),
      .i_avs_read       (avs_read),
      .i_avs_write      (avs_write),
      .i_avs_writedata  (avs_writedata),
      .i_avs_byteenable (4'h1),
      .o_avs_readdata   (avs_readdata),
      .o_avs_waitrequest(avs_waitrequest),
      .i_init_mode      (init_mode),
      .i_id_valid       (id_valid),
      .i_id_word        (id_word),
      .o_id_done        (id_done),
      .o_id_accept      (id_accept),
      .o_match_index    (match_index)
   );

   caf_id_src i_caf_id_src (
      .i_core_clk(clk),
      .o_id_valid(id_valid),
      .o_id_word (id_word)
   );

   always #2 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // Request held until waitrequest is sampled low; data taken at that edge
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_read      <= !wr;
      avs_write     <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) check(32'h0000_0001, 32'h0000_0000, "bus answer missing");
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      xfer(a, 1'b0, 8'h00, q);
      check(q, {24'h000000, exp}, "register read");
   endtask : rd_chk

   // Result one cycle after the offer, done lasting exactly one cycle
   task automatic id_chk(input logic [31:0] w, input logic acc, input logic [2:0] idx);
      i_caf_id_src.send(w);
      #1;
      check(id_done, 1'b1, "done pulse");
      check(id_accept, acc, "accept");
      check(match_index, idx, "match index");
      @(posedge clk);
      #1;
      check(id_done, 1'b0, "done width");
   endtask : id_chk

   function automatic logic [7:0] win(input int f, input int b);
      return CAF_ADDR_WIN_BASE + 8'(4 * (8 * (f % 2) + b));
   endfunction : win

   task automatic t_reset();
      logic [7:0] a [5] = '{CAF_ADDR_PAGE, CAF_ADDR_CTRL23, CAF_ADDR_CTRL45,
                            CAF_ADDR_MODE_LO, CAF_ADDR_MODE_HI};
      foreach (a[i]) rd_chk(a[i], 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_ctrl();
      wr(CAF_ADDR_CTRL23, 8'hFF);
      rd_chk(CAF_ADDR_CTRL23, 8'h77);
      wr(CAF_ADDR_CTRL45, 8'hFF);
      rd_chk(CAF_ADDR_CTRL45, 8'h77);
      wr(CAF_ADDR_CTRL45, 8'h12);
      rd_chk(CAF_ADDR_CTRL45, 8'h12);
      @(posedge clk) init_mode <= 1'b0;
      wr(CAF_ADDR_CTRL23, 8'h00);
      rd_chk(CAF_ADDR_CTRL23, 8'h66);
      @(posedge clk) init_mode <= 1'b1;
      wr(CAF_ADDR_CTRL23, 8'h00);
      wr(CAF_ADDR_CTRL45, 8'h00);
      rd_chk(CAF_ADDR_CTRL23, 8'h00);
      rd_chk(CAF_ADDR_CTRL45, 8'h00);
      $display("t_ctrl done");
   endtask : t_ctrl

   task automatic t_mode();
      wr(CAF_ADDR_MODE_LO, 8'hA5);
      rd_chk(CAF_ADDR_MODE_LO, 8'hA5);
      wr(CAF_ADDR_MODE_LO, 8'h5A);
      rd_chk(CAF_ADDR_MODE_LO, 8'h5A);
      wr(CAF_ADDR_MODE_HI, 8'hFF);
      rd_chk(CAF_ADDR_MODE_HI, 8'h0F);
      wr(CAF_ADDR_MODE_LO, 8'h00);
      wr(CAF_ADDR_MODE_HI, 8'h00);
      $display("t_mode done");
   endtask : t_mode

   task automatic t_window();
      for (int p = 2; p <= 4; p++) begin
         wr(CAF_ADDR_PAGE, 8'(p));
         wr(win(1, 7), 8'(8'h30 + p));
      end
      rd_chk(CAF_ADDR_PAGE, 8'h04);
      wr(CAF_ADDR_PAGE, {5'h00, CAF_PAGE_F23});
      for (int b = 0; b < 8; b++) begin
         wr(win(2, b), FB[b]);
         wr(win(3, b), FB[b]);
      end
      for (int b = 0; b < 8; b++) begin
         rd_chk(win(2, b), FB[b]);
         rd_chk(win(3, b), FB[b]);
      end
      for (int p = 2; p <= 4; p += 2) begin
         wr(CAF_ADDR_PAGE, 8'(p));
         rd_chk(win(1, 7), 8'(8'h30 + p));
      end
      wr(CAF_ADDR_PAGE, 8'h05);
      rd_chk(win(2, 0), 8'h00);
      rd_chk(8'h20, 8'h00);
      wr(CAF_ADDR_PAGE, {5'h00, CAF_PAGE_F23});
      $display("t_window done");
   endtask : t_window

   // Filter 2 as one 32-bit filter: id 12345678, mask FFF00000
   task automatic t_match();
      wr(CAF_ADDR_CTRL23, 8'h05);
      wr(win(2, 0), 8'hAA);
      rd_chk(win(2, 0), 8'h12);
      id_chk(32'h1334_5678, 1'b0, 3'h0);
      id_chk(32'h123F_AAAA, 1'b1, 3'h2);
      rd_chk(CAF_ADDR_STATUS, 8'h0A);
      wr(CAF_ADDR_MODE_LO, 8'h10);
      id_chk(32'hFFF0_0000, 1'b1, 3'h2);
      id_chk(32'h123F_AAAA, 1'b0, 3'h0);
      wr(CAF_ADDR_CTRL23, 8'h55);
      id_chk(32'h123F_AAAA, 1'b1, 3'h3);
      id_chk(32'h1234_5678, 1'b1, 3'h2);
      wr(CAF_ADDR_CTRL23, 8'h44);
      id_chk(32'h1234_5678, 1'b0, 3'h0);
      $display("t_match done");
   endtask : t_match

   // Filter 0 loaded while inactive, then tried at each scale
   task automatic t_scale();
      wr(CAF_ADDR_PAGE, {5'h00, CAF_PAGE_F01});
      for (int b = 0; b < 8; b++) wr(win(0, b), (b < 4) ? FB[b] : 8'h00);
      wr(CAF_ADDR_CTRL01, 8'h05);
      rd_chk(CAF_ADDR_CTRL01, 8'h05);
      id_chk(32'hDEAD_BEEF, 1'b1, 3'h0);
      wr(CAF_ADDR_MODE_LO, 8'h01);
      id_chk(32'h1234_5678, 1'b1, 3'h0);
      id_chk(32'h1234_5679, 1'b0, 3'h0);
      wr(CAF_ADDR_MODE_LO, 8'h03);
      wr(CAF_ADDR_CTRL01, 8'h03);
      id_chk(32'h5678_0000, 1'b1, 3'h0);
      id_chk(32'h1235_0000, 1'b0, 3'h0);
      wr(CAF_ADDR_CTRL01, 8'h01);
      id_chk(32'h12FF_FFFF, 1'b1, 3'h0);
      @(posedge clk) ce <= 1'b0;
      i_caf_id_src.send(32'h12FF_FFFF);
      #1 check(id_done, 1'b0, "frozen done");
      @(posedge clk) ce <= 1'b1;
      $display("t_scale done");
   endtask : t_scale

   initial begin
      clk             = 1'b0;
      rst             = 1'b1;
      avs_address     = 8'h00;
      avs_read        = 1'b0;
      avs_write       = 1'b0;
      avs_writedata   = 32'h0000_0000;
      init_mode       = 1'b1;
      ce              = 1'b1;
      n_mismatch      = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ctrl();
      t_mode();
      t_window();
      t_match();
      t_scale();
      final_report();
   end

   // Run needs a few hundred cycles; a hang is cut well beyond that
   initial begin
      #100000;
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
endmodule : caf_filter_top_tb
